// ===== common/rca_pkg.sv
// Purpose: shared constants and types for the risc core and its alu
// Assumes: 12-bit instruction words, 8-bit data words
// Notes:   mapped control register offsets live in the data space
package rca_pkg;

  // word widths
  localparam int INSN_W  = 12;
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 5;
  localparam int IP_W_DEF = 10;

  // timing: one instruction cycle is four clock phases
  localparam int CLK_PERIOD_NS      = 100;
  localparam int PHASES_PER_CYCLE   = 4;
  localparam int INSN_CYCLE_FAST_NS = 200;
  localparam int INSN_CYCLE_CLKS    = PHASES_PER_CYCLE;
  localparam int INSN_CYCLE_NS      = INSN_CYCLE_CLKS * CLK_PERIOD_NS;

  // mapped control register offsets in data space
  localparam logic [4:0] ADDR_INDIRECT = 5'h00;
  localparam logic [4:0] ADDR_IP       = 5'h02;
  localparam logic [4:0] ADDR_STATUS   = 5'h03;
  localparam logic [4:0] ADDR_POINTER  = 5'h04;

  // status field positions
  localparam int ST_CARRY  = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO   = 2;

  // reset values
  localparam logic [7:0]  STATUS_RST  = 8'h00;
  localparam logic [7:0]  POINTER_RST = 8'h00;
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [11:0] INSN_NOP    = 12'h000;

  // file operation codes, insn[11:6]; d = insn[5], f = insn[4:0]
  localparam logic [5:0] OPF_MOVE_W  = 6'h00;
  localparam logic [5:0] OPF_CLEAR   = 6'h01;
  localparam logic [5:0] OPF_SUB     = 6'h02;
  localparam logic [5:0] OPF_DEC     = 6'h03;
  localparam logic [5:0] OPF_IOR     = 6'h04;
  localparam logic [5:0] OPF_AND     = 6'h05;
  localparam logic [5:0] OPF_XOR     = 6'h06;
  localparam logic [5:0] OPF_ADD     = 6'h07;
  localparam logic [5:0] OPF_MOVF    = 6'h08;
  localparam logic [5:0] OPF_COM     = 6'h09;
  localparam logic [5:0] OPF_INC     = 6'h0A;
  localparam logic [5:0] OPF_RR      = 6'h0C;
  localparam logic [5:0] OPF_RL      = 6'h0D;

  // literal operation codes, insn[11:8]; k = insn[7:0]
  localparam logic [3:0] OPL_MOVLW = 4'hC;
  localparam logic [3:0] OPL_IORLW = 4'hD;
  localparam logic [3:0] OPL_ANDLW = 4'hE;
  localparam logic [3:0] OPL_XORLW = 4'hF;

  // branch code, insn[11:9]; target = insn[8:0]
  localparam logic [2:0] OPB_GOTO = 3'h5;

  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_PASS,
    ALU_COM, ALU_INC, ALU_DEC, ALU_RR, ALU_RL, ALU_CLR
  } rca_alu_op_t;

  typedef enum logic [1:0] {
    PHASE_ONE, PHASE_TWO, PHASE_THREE, PHASE_FOUR
  } rca_phase_t;

endpackage : rca_pkg

// ===== core/rca_alu.sv
// Purpose: 8-bit alu with carry, nibble carry and zero results
// Assumes: purely combinational, operands from the core
// Notes:   carry reads as "no borrow" after subtraction
`timescale 1ns/1ps
`default_nettype none
module rca_alu
  import rca_pkg::*;
(
  // operation and operands
  input  wire rca_alu_op_t op,
  input  wire logic [7:0]  opnd,
  input  wire logic [7:0]  acc,
  input  wire logic        cin,
  // results
  output logic [7:0]       res,
  output logic             c_out,
  output logic             dc_out,
  output logic             z_out,
  output logic             upd_c,
  output logic             upd_dc,
  output logic             upd_z
);

  logic [8:0] sum9;
  logic [4:0] sum5;

  // two's complement: subtract adds the inverted accumulator plus one
  always_comb
  begin
    sum9   = 9'h000;
    sum5   = 5'h00;
    res    = opnd;
    c_out  = cin;
    dc_out = 1'b0;
    upd_c  = 1'b0;
    upd_dc = 1'b0;
    upd_z  = 1'b1;
    case (op)
      ALU_ADD:
      begin
        sum9   = {1'b0, opnd} + {1'b0, acc};
        sum5   = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
        res    = sum9[7:0];
        c_out  = sum9[8];
        dc_out = sum5[4];
        upd_c  = 1'b1;
        upd_dc = 1'b1;
      end
      ALU_SUB:
      begin
        sum9   = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
        sum5   = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
        res    = sum9[7:0];
        c_out  = sum9[8];
        dc_out = sum5[4];
        upd_c  = 1'b1;
        upd_dc = 1'b1;
      end
      ALU_AND:  res = opnd & acc;
      ALU_IOR:  res = opnd | acc;
      ALU_XOR:  res = opnd ^ acc;
      ALU_PASS: res = opnd;
      ALU_COM:  res = ~opnd;
      ALU_INC:  res = opnd + 8'h01;
      ALU_DEC:  res = opnd - 8'h01;
      ALU_CLR:  res = 8'h00;
      ALU_RR:
      begin
        res   = {cin, opnd[7:1]};
        c_out = opnd[0];
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      ALU_RL:
      begin
        res   = {opnd[6:0], cin};
        c_out = opnd[7];
        upd_c = 1'b1;
        upd_z = 1'b0;
      end
      default: res = opnd;
    endcase
    z_out = (res == 8'h00);
  end

endmodule : rca_alu
`default_nettype wire

// ===== core/rca_core.sv
// Purpose: two-stage pipelined 8-bit core with 12-bit instruction fetch
// Assumes: program and data memories answer within two clocks of an address
// Notes:   one instruction cycle is four clocks; goto costs two cycles
`timescale 1ns/1ps
`default_nettype none
module rca_core
  import rca_pkg::*;
#(
  parameter int IP_W = IP_W_DEF
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // program memory bus
  output logic [IP_W-1:0]        prog_addr,
  input  wire logic [INSN_W-1:0] prog_data,
  // data memory bus
  output logic [FADDR_W-1:0]     data_addr,
  output logic [DATA_W-1:0]      data_wdata,
  output logic                   data_we,
  input  wire logic [DATA_W-1:0] data_rdata,
  // observation
  output logic [DATA_W-1:0]      acc_value,
  output logic [DATA_W-1:0]      status_value
);

  // goto carries a 9-bit target; the pointer must hold it
  if (IP_W < 9 || IP_W > 12)
  begin : g_chk_ip_w
    $error("rca_core: IP_W must lie in 9..12");
  end

  rca_phase_t          phase_q, phase_d;
  logic [IP_W-1:0]     ip_q, ip_d;
  logic [IP_W-1:0]     paddr_q, paddr_d;
  logic [INSN_W-1:0]   ir_q, ir_d;
  logic [7:0]          acc_q, acc_d;
  logic [7:0]          status_q, status_d;
  logic [7:0]          pointer_q, pointer_d;
  logic [FADDR_W-1:0]  daddr_q, daddr_d;
  logic [7:0]          wdata_q, wdata_d;
  logic                we_q, we_d;
  logic [7:0]          res_q, res_d;
  logic [2:0]          flg_q, flg_d;
  logic [2:0]          upd_q, upd_d;

  // decode results
  logic                is_goto;
  logic                is_lit;
  logic                to_file;
  logic                flags_ok;
  logic                use_file;
  rca_alu_op_t         alu_op;
  logic [5:0]          fop;
  logic [FADDR_W-1:0]  eff_addr;
  logic [7:0]          file_val;
  logic [7:0]          opnd;
  // alu results
  logic [7:0]          alu_res;
  logic                alu_c;
  logic                alu_dc;
  logic                alu_z;
  logic                alu_uc;
  logic                alu_udc;
  logic                alu_uz;

  // instruction decode of the word held in the instruction register
  always_comb
  begin
    fop      = ir_q[11:6];
    is_goto  = (ir_q[11:9] == OPB_GOTO);
    is_lit   = (ir_q[11:10] == 2'b11);
    to_file  = 1'b0;
    flags_ok = 1'b1;
    use_file = 1'b1;
    alu_op   = ALU_PASS;
    if (is_lit)
    begin
      use_file = 1'b0;
      case (ir_q[11:8])
        OPL_MOVLW:
        begin
          alu_op   = ALU_PASS;
          flags_ok = 1'b0;
        end
        OPL_IORLW: alu_op = ALU_IOR;
        OPL_ANDLW: alu_op = ALU_AND;
        OPL_XORLW: alu_op = ALU_XOR;
        default:   alu_op = ALU_PASS;
      endcase
    end
    else if (is_goto || ir_q[11:10] == 2'b10)
    begin
      // branch and unused codes change no data
      flags_ok = 1'b0;
    end
    else
    begin
      // single operand: result to accumulator or file
      to_file = ir_q[5];
      case (fop)
        OPF_MOVE_W:
        begin
          // movwf when d=1, no-op otherwise
          alu_op   = ALU_PASS;
          use_file = 1'b0;
          flags_ok = 1'b0;
        end
        OPF_CLEAR: alu_op = ALU_CLR;
        OPF_SUB:   alu_op = ALU_SUB;
        OPF_DEC:   alu_op = ALU_DEC;
        OPF_IOR:   alu_op = ALU_IOR;
        OPF_AND:   alu_op = ALU_AND;
        OPF_XOR:   alu_op = ALU_XOR;
        OPF_ADD:   alu_op = ALU_ADD;
        OPF_MOVF:  alu_op = ALU_PASS;
        OPF_COM:   alu_op = ALU_COM;
        OPF_INC:   alu_op = ALU_INC;
        OPF_RR:    alu_op = ALU_RR;
        OPF_RL:    alu_op = ALU_RL;
        default:
        begin
          alu_op   = ALU_PASS;
          to_file  = 1'b0;
          flags_ok = 1'b0;
          use_file = 1'b0;
        end
      endcase
    end
  end

  // file 0 reaches memory through the pointer register
  assign eff_addr = (ir_q[4:0] == ADDR_INDIRECT) ? pointer_q[FADDR_W-1:0] : ir_q[4:0];

  // mapped control registers answer from the core, rest from memory
  always_comb
  begin
    case (daddr_q)
      ADDR_INDIRECT: file_val = 8'h00; // pointer aimed at file 0 reads zero
      ADDR_IP:       file_val = ip_q[7:0];
      ADDR_STATUS:   file_val = status_q;
      ADDR_POINTER:  file_val = pointer_q;
      default:       file_val = data_rdata;
    endcase
  end

  // accumulator is core-private, movwf passes it as the operand
  assign opnd = use_file ? file_val : (is_lit ? ir_q[7:0] : acc_q);

  rca_alu u_alu (
    .op     (alu_op),
    .opnd   (opnd),
    .acc    (acc_q),
    .cin    (status_q[ST_CARRY]),
    .res    (alu_res),
    .c_out  (alu_c),
    .dc_out (alu_dc),
    .z_out  (alu_z),
    .upd_c  (alu_uc),
    .upd_dc (alu_udc),
    .upd_z  (alu_uz)
  );

  // phase sequencer, fetch and execute next values
  always_comb
  begin
    phase_d   = phase_q;
    ip_d      = ip_q;
    paddr_d   = paddr_q;
    ir_d      = ir_q;
    acc_d     = acc_q;
    status_d  = status_q;
    pointer_d = pointer_q;
    daddr_d   = daddr_q;
    wdata_d   = wdata_q;
    we_d      = 1'b0; // write strobe lasts one clock only
    res_d     = res_q;
    flg_d     = flg_q;
    upd_d     = upd_q;
    // four phases make one instruction cycle
    case (phase_q)
      PHASE_ONE:
      begin
        phase_d = PHASE_TWO;
        // pointer advances, fetch address goes out
        paddr_d = ip_q;
        ip_d    = ip_q + {{(IP_W-1){1'b0}}, 1'b1};
        // data address on its own bus
        daddr_d = eff_addr;
      end
      PHASE_TWO:
      begin
        phase_d = PHASE_THREE;
      end
      PHASE_THREE:
      begin
        phase_d = PHASE_FOUR;
        // alu result captured once operands settled
        res_d = alu_res;
        upd_d = flags_ok ? {alu_uz, alu_udc, alu_uc} : 3'b000;
        // zero flag from full 8-bit result
        // nibble flag from bit 3 carry
        // subtraction flags hold the no-borrow sense
        flg_d = {alu_z, alu_dc, alu_c};
      end
      PHASE_FOUR:
      begin
        phase_d = PHASE_ONE;
        // next 12-bit word enters the instruction register
        // fetched while the current word finished executing
        ir_d = prog_data;
        if (to_file)
        begin
          case (daddr_q)
            ADDR_IP:
            begin
              // writing the pointer branches, flush costs a cycle
              ip_d = {ip_q[IP_W-1:8], res_q};
              ir_d = INSN_NOP;
            end
            ADDR_STATUS:  status_d = res_q;
            ADDR_POINTER: pointer_d = res_q;
            ADDR_INDIRECT: ;
            default:
            begin
              we_d    = 1'b1;
              wdata_d = res_q;
            end
          endcase
        end
        // branch and unused 10xx codes leave the accumulator alone
        else if (ir_q[11:10] != 2'b10 && (is_lit || fop != OPF_MOVE_W))
        begin
          acc_d = res_q;
        end
        if (ir_q[11:5] == {OPF_MOVE_W, 1'b0})
        begin
          acc_d = acc_q; // plain no-op keeps accumulator
        end
        // goto discards the prefetched word, two cycles total
        if (is_goto)
        begin
          ip_d = {{(IP_W-9){1'b0}}, ir_q[8:0]};
          ir_d = INSN_NOP;
        end
        // flag updates land after any status write
        if (upd_q[0])
        begin
          status_d[ST_CARRY] = flg_q[0];
        end
        if (upd_q[1])
        begin
          status_d[ST_NIBBLE] = flg_q[1];
        end
        if (upd_q[2])
        begin
          status_d[ST_ZERO] = flg_q[2];
        end
      end
      default: phase_d = PHASE_ONE;
    endcase
  end

  // state registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phase_q   <= PHASE_ONE;
      ip_q      <= '0;
      paddr_q   <= '0;
      ir_q      <= INSN_NOP;
      acc_q     <= ACC_RST;
      status_q  <= STATUS_RST;
      pointer_q <= POINTER_RST;
      daddr_q   <= '0;
      wdata_q   <= 8'h00;
      we_q      <= 1'b0;
      res_q     <= 8'h00;
      flg_q     <= 3'b000;
      upd_q     <= 3'b000;
    end
    else
    begin
      phase_q   <= phase_d;
      ip_q      <= ip_d;
      paddr_q   <= paddr_d;
      ir_q      <= ir_d;
      acc_q     <= acc_d;
      status_q  <= status_d;
      pointer_q <= pointer_d;
      daddr_q   <= daddr_d;
      wdata_q   <= wdata_d;
      we_q      <= we_d;
      res_q     <= res_d;
      flg_q     <= flg_d;
      upd_q     <= upd_d;
    end
  end

  // outputs straight from registers
  assign prog_addr    = paddr_q;
  assign data_addr    = daddr_q;
  assign data_wdata   = wdata_q;
  assign data_we      = we_q;
  assign acc_value    = acc_q;
  assign status_value = status_q;

endmodule : rca_core
`default_nettype wire

// ===== bench/rca_core_sva.sv
// Purpose: timing checks on the core's program and data buses
// Assumes: sees only the ports of rca_core, one clock domain
// Notes:   phase edges are inferred from fetch address changes
`timescale 1ns/1ps
`default_nettype none
module rca_core_sva
  import rca_pkg::*;
#(
  parameter int IP_W = IP_W_DEF
)(
  // clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // program bus
  input wire logic [IP_W-1:0]    prog_addr,
  input wire logic [INSN_W-1:0]  prog_data,
  // data bus
  input wire logic [FADDR_W-1:0] data_addr,
  input wire logic [DATA_W-1:0]  data_wdata,
  input wire logic               data_we,
  input wire logic [DATA_W-1:0]  data_rdata,
  // observation
  input wire logic [DATA_W-1:0]  acc_value,
  input wire logic [DATA_W-1:0]  status_value
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // end of phase one is marked by a new fetch address
  sequence s_fetch_next;
    ##1 $changed(prog_addr);
  endsequence

  // write strobe with the address still held, then the next fetch address
  sequence s_write_then_fetch;
    $stable(data_addr) ##1 $changed(prog_addr);
  endsequence

  // write aimed at an address the core serves itself
  logic wr_mapped;
  assign wr_mapped = data_addr inside {ADDR_INDIRECT, ADDR_IP, ADDR_STATUS, ADDR_POINTER};

  // bus holds and one fetch per four clocks
  a_fetch_addr_hold: assert property ($changed(prog_addr) |=> $stable(prog_addr)[*3])
    else $error("fetch address moved inside a cycle");
  a_fetch_cycle_rate: assert property ($changed(prog_addr) |-> ##4 $changed(prog_addr))
    else $error("fetch not repeated after four clocks");
  a_data_addr_hold: assert property ($changed(data_addr) |=> $stable(data_addr)[*3])
    else $error("data address moved inside a cycle");
  a_data_fetch_align: assert property ($changed(data_addr) |-> $changed(prog_addr))
    else $error("data address not updated with fetch");
  a_write_one_clock: assert property (data_we |=> !data_we)
    else $error("write strobe longer than one clock");
  a_write_not_mapped: assert property (data_we |-> !wr_mapped)
    else $error("write strobe for a mapped control address");
  a_write_phase_four: assert property (data_we |-> s_write_then_fetch)
    else $error("write not at end of phase four");
  a_acc_phase_four: assert property ($changed(acc_value) |-> s_fetch_next)
    else $error("accumulator update off phase four");
  a_status_phase_four: assert property ($changed(status_value) |-> s_fetch_next)
    else $error("status update off phase four");
endmodule : rca_core_sva

bind rca_core rca_core_sva #(.IP_W(IP_W)) u_sva (.clk(clk), .rst(rst), .prog_addr(prog_addr),
  .prog_data(prog_data), .data_addr(data_addr), .data_wdata(data_wdata), .data_we(data_we),
  .data_rdata(data_rdata), .acc_value(acc_value), .status_value(status_value));
`default_nettype wire

// ===== bench/rca_mem_model.sv
// Purpose: program and data memory arrays facing the core
// Assumes: answers combinationally, well inside the core's wait
// Notes:   a load port fills program words while the core is in reset
`timescale 1ns/1ps
`default_nettype none
module rca_mem_model
  import rca_pkg::*;
#(
  parameter int IP_W = IP_W_DEF
)(
  // clock
  input wire logic               clk,
  // program bus
  input wire logic [IP_W-1:0]    prog_addr,
  output logic [INSN_W-1:0]      prog_data,
  // data bus
  input wire logic [FADDR_W-1:0] data_addr,
  input wire logic [DATA_W-1:0]  data_wdata,
  input wire logic               data_we,
  output logic [DATA_W-1:0]      data_rdata,
  // loading and inspection
  input wire logic               ld_we,
  input wire logic [IP_W-1:0]    ld_addr,
  input wire logic [INSN_W-1:0]  ld_data,
  input wire logic [FADDR_W-1:0] peek_addr,
  output logic [DATA_W-1:0]      peek_data
);
  // empty words read as nop so a stray fetch stays harmless
  logic [INSN_W-1:0] rom [1<<IP_W] = '{default: INSN_NOP};
  logic [DATA_W-1:0] ram [1<<FADDR_W] = '{default: 8'h00};

  // writes land on the clock edge
  always @(posedge clk)
  begin
    if (ld_we) rom[ld_addr] <= ld_data;
    if (data_we) ram[data_addr] <= data_wdata;
  end

  // read ports
  assign prog_data  = rom[prog_addr];
  assign data_rdata = ram[data_addr];
  assign peek_data  = ram[peek_addr];
endmodule : rca_mem_model
`default_nettype wire

// ===== bench/tb.sv
// Purpose: self-checking bench running short programs on the core
// Assumes: memory model answers at once; four words plus a goto loop
// Notes:   operands from an lfsr seeded at 71BD, corner pairs first
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rca_pkg::*;
  localparam int IPW = IP_W_DEF;
  localparam int CYC_LIMIT = 10000;
  localparam logic [5:0] OPS [12] = '{OPF_ADD, OPF_SUB, OPF_AND, OPF_IOR, OPF_XOR,
                                      OPF_INC, OPF_DEC, OPF_COM, OPF_RR, OPF_RL, OPF_CLEAR, OPF_MOVF};
  logic              clk, rst, data_we, ld_we;
  logic [IPW-1:0]    prog_addr, ld_addr;
  logic [11:0]       prog_data, ld_data;
  logic [4:0]        data_addr, peek_addr;
  logic [7:0]        data_wdata, data_rdata, acc_value, status_value, peek_data, a, b;
  logic [31:0]       lfsr;
  int                num_errors, check_count;
  int                cycles = 0;

  rca_core u_dut (.clk(clk), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data),
    .data_addr(data_addr), .data_wdata(data_wdata), .data_we(data_we), .data_rdata(data_rdata),
    .acc_value(acc_value), .status_value(status_value));
  rca_mem_model u_mem (.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
    .data_wdata(data_wdata), .data_we(data_we), .data_rdata(data_rdata), .ld_we(ld_we),
    .ld_addr(ld_addr), .ld_data(ld_data), .peek_addr(peek_addr), .peek_data(peek_data));

  // 100 ns clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next

  // expected {z, nibble, carry, result}; file operand a, accumulator b
  function automatic logic [10:0] exp_alu(input logic [5:0] op, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic       c, dc, zon;
    c = 1'b0; dc = 1'b0; zon = 1'b1;
    case (op)
      OPF_ADD: begin s = a + b; c = s[8]; dc = ({1'b0, a[3:0]} + b[3:0]) > 5'h0F; end
      OPF_SUB: begin s = {1'b0, a - b}; c = a >= b; dc = a[3:0] >= b[3:0]; end
      OPF_AND: s = {1'b0, a & b};
      OPF_IOR: s = {1'b0, a | b};
      OPF_XOR: s = {1'b0, a ^ b};
      OPF_INC: s = {1'b0, a + 8'h01};
      OPF_DEC: s = {1'b0, a - 8'h01};
      OPF_COM: s = {1'b0, ~a};
      OPF_CLEAR: s = 9'h000;
      OPF_MOVF: s = {1'b0, a};
      OPF_RR:  begin s = {2'b00, a[7:1]}; c = a[0]; zon = 1'b0; end
      default: begin s = {1'b0, a[6:0], 1'b0}; c = a[7]; zon = 1'b0; end
    endcase
    return {zon && (s[7:0] == 8'h00), dc, c, s[7:0]};
  endfunction : exp_alu

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // load under reset, run, then inspect file, accumulator and flags
  task automatic run_case(input logic [5:0] op, input logic [7:0] a, input logic [7:0] b, input logic d);
    logic [10:0] e;
    logic [11:0] prog [6];
    e = exp_alu(op, a, b);
    prog = '{{OPL_MOVLW, a}, 12'h030, {OPL_MOVLW, b}, {op, d, 5'h10}, 12'hA04, {OPL_MOVLW, 8'hEE}};
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk);
      rst <= 1'b1;
      ld_we <= 1'b1;
      ld_addr <= k[IPW-1:0];
      ld_data <= prog[k];
    end
    @(posedge clk);
    ld_we <= 1'b0;
    rst <= 1'b0;
    #1;
    check("acc after reset", acc_value, ACC_RST);
    check("status after reset", status_value, STATUS_RST);
    // ten instruction cycles of four clocks each
    repeat (40) @(posedge clk);
    #1;
    check("file result", peek_data, d ? e[7:0] : a);
    check("accumulator", acc_value, d ? b : e[7:0]);
    check("status flags", status_value, {5'h00, e[10:8]});
    $display("case op %h a %h b %h d %b done", op, a, b, d);
  endtask : run_case

  // free-running cycle count for the hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
  end

  initial
  begin
    rst = 1'b1; ld_we = 1'b0; ld_addr = '0; ld_data = '0; peek_addr = 5'h10;
    lfsr = 32'h71BD; num_errors = 0; check_count = 0;
    fork
      begin
        for (int i = 0; i < 12; i++)
        begin
          for (int t = 0; t < 6; t++)
          begin
            lfsr = lfsr_next(lfsr);
            a = (t == 0) ? 8'h00 : (t == 1) ? 8'hFF : (t == 2) ? 8'h0F : lfsr[7:0];
            b = (t == 0) ? 8'h00 : (t < 3) ? 8'h01 : lfsr[15:8];
            run_case(OPS[i], a, b, lfsr[16]);
          end
        end
      end
      begin
        // a stuck run counts as a mismatch and still reaches the report
        wait (cycles == CYC_LIMIT);
        num_errors++;
      end
    join_any
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
